// ### core/cfd_clock_fail_detector.sv
// clock failure detector with glitch-free switch to the safe clock
// Behaviour
// - watch external oscillator; on failure swap system clock to safe clock.
// - stay on safe clock until reset, then return and monitor again.
// - safe clock is 8 MHz RC divided by eight, giving 1 MHz.
// - prescale register stays writable while running on the safe clock.
// - monitor runs on 128 kHz ticks; that oscillator enabled with detector.
// - fuse bit off means no monitoring and no clock switching.
// - no detection until oscillator start-up time after each start.
// - no external clock at all falls back to the RC oscillator.
// - failure sets read-only flag in bit 1, cleared only by reset.
// - interrupt request while failure flag and its enable are set.
// - enable bit 0 can be set, never cleared by software.
// - detection off in power-save or power-down, back on when active.
// - failure selects RC source code 0010 with safe prescale.
// - RC oscillator enabled only after a failure is detected.
// - prescale change needs 0x80 write then value within four cycles.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`include "cfd_defines.svh"

module cfd_clock_fail_detector
    import cfd_pkg::*;
#(
    parameter int unsigned EXTERNAL_OSC_CLOCK_STARTUP_US = `CFD_EXTERNAL_OSC_CLOCK_STARTUP_US,
    parameter int unsigned FAIL_TICKS = `CFD_FAIL_TICKS
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic cfd_fuse_en,
    input wire logic external_osc_clock_clk_in,
    input wire logic mon_tick,
    input wire logic sleep_deep,
    output cfd_clk_ctrl_t clk_ctrl,
    output logic [3:0] prescale_select,
    output logic irq
);

    // ---------------------------------------------------------------
    // derived counts
    // ---------------------------------------------------------------
    localparam int unsigned START_TICKS =
        (EXTERNAL_OSC_CLOCK_STARTUP_US * `CFD_MON_CLK_HZ + 999999) / 1000000;
    localparam int unsigned GAP_CYC_RAW = (`CFD_GATE_GAP_NS + `CFD_SYS_PERIOD_NS - 1)
        / `CFD_SYS_PERIOD_NS;
    localparam int unsigned WAKE_CYC_RAW = (`CFD_RC_WAKE_NS + `CFD_SYS_PERIOD_NS - 1)
        / `CFD_SYS_PERIOD_NS;
    localparam logic [7:0] GAP_CYC = 8'(GAP_CYC_RAW < 1 ? 1 : GAP_CYC_RAW);
    localparam logic [7:0] WAKE_CYC = 8'(WAKE_CYC_RAW < 1 ? 1 : WAKE_CYC_RAW);
    localparam logic [15:0] START_T = 16'(START_TICKS < 1 ? 1 : START_TICKS);
    localparam logic [3:0] FAIL_T = 4'(FAIL_TICKS);

    // refuse tick counts that the counters cannot hold
    if (FAIL_TICKS < 1 || FAIL_TICKS > 15 || START_TICKS > 65535) begin : g_bad_ticks
        $error("cfd_clock_fail_detector: unsupported tick counts");
    end

    // true when the address is the byte address of a register index
    function automatic logic addr_hit(input logic [9:0] a, input logic [7:0] idx);
        addr_hit = (a == {idx, 2'b00});
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    cfd_state_t state_ff, nxt_state;
    logic [15:0] tick_cnt_ff, nxt_tick_cnt;
    logic [3:0] miss_cnt_ff, nxt_miss_cnt;
    logic [7:0] cyc_cnt_ff, nxt_cyc_cnt;
    logic external_osc_clock_q_ff;
    logic edge_seen_ff;
    logic ever_edge_ff;
    logic fail_flag_ff;
    logic fail_ie_ff;
    logic [1:0] irq_stat_ff;
    logic [1:0] irq_mask_ff;
    logic irq_ff;
    logic waitreq_ff;
    logic [31:0] rdata_ff;
    cfd_clk_ctrl_t clk_ctrl_ff, nxt_clk_ctrl;
    logic [7:0] ps_readback;
    logic ps_changed;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    wire req = read || write;
    wire acc = req && !waitreq_ff;
    wire wr_acc = acc && write;
    wire hit_ps = addr_hit(address, `CFD_IDX_PRESCALE);
    wire hit_csr = addr_hit(address, `CFD_IDX_FAILCSR);
    wire hit_stat = addr_hit(address, `CFD_IDX_IRQ_STAT);
    wire hit_mask = addr_hit(address, `CFD_IDX_IRQ_MASK);
    wire hit_state = addr_hit(address, `CFD_IDX_STATE);
    wire [7:0] csr_val = {6'h00, fail_flag_ff, fail_ie_ff};
    wire [31:0] rd_mux = hit_ps ? {24'h000000, ps_readback} :
                         hit_csr ? {24'h000000, csr_val} :
                         hit_stat ? {30'h00000000, irq_stat_ff} :
                         hit_mask ? {30'h00000000, irq_mask_ff} :
                         hit_state ? {28'h0000000, clk_ctrl_ff.rc_gate, state_ff} :
                         32'h00000000;

    // ---------------------------------------------------------------
    // monitor events
    // ---------------------------------------------------------------
    wire external_osc_clock_edge = external_osc_clock_clk_in != external_osc_clock_q_ff;
    wire edge_now = edge_seen_ff || external_osc_clock_edge;
    wire start_done = mon_tick && (tick_cnt_ff + 16'h0001 >= START_T);
    wire miss_out = mon_tick && !edge_now && (miss_cnt_ff + 4'h1 >= FAIL_T);
    wire no_clock = start_done && !ever_edge_ff && !external_osc_clock_edge;
    wire fail_event = ((state_ff == CFD_ST_MONITOR) && miss_out && !sleep_deep) ||
                      ((state_ff == CFD_ST_STARTUP) && no_clock && !sleep_deep);
    wire ps_force = (state_ff == CFD_ST_GATE_OFF) && (cyc_cnt_ff == 8'h01);

    // edge capture of the sampled external clock
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            // follow the pin so release does not fake an edge
            external_osc_clock_q_ff <= external_osc_clock_clk_in;
            edge_seen_ff <= 1'b0;
            ever_edge_ff <= 1'b0;
        end else begin
            external_osc_clock_q_ff <= external_osc_clock_clk_in;
            edge_seen_ff <= mon_tick ? 1'b0 : edge_now;
            ever_edge_ff <= (state_ff == CFD_ST_STARTUP && sleep_deep) ? 1'b0 :
                            (ever_edge_ff || external_osc_clock_edge);
        end
    end

    // ---------------------------------------------------------------
    // sequence control
    // ---------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_tick_cnt = tick_cnt_ff;
        nxt_miss_cnt = miss_cnt_ff;
        nxt_cyc_cnt = cyc_cnt_ff;
        case (state_ff)
            CFD_ST_IDLE: begin
                if (cfd_fuse_en) begin
                    nxt_state = CFD_ST_STARTUP;
                    nxt_tick_cnt = 16'h0000;
                end
            end
            CFD_ST_STARTUP: begin
                if (sleep_deep) begin
                    nxt_tick_cnt = 16'h0000;
                end else if (fail_event) begin
                    nxt_state = CFD_ST_GATE_OFF;
                    nxt_cyc_cnt = GAP_CYC;
                end else if (start_done) begin
                    nxt_state = CFD_ST_MONITOR;
                    nxt_miss_cnt = 4'h0;
                end else if (mon_tick) begin
                    nxt_tick_cnt = tick_cnt_ff + 16'h0001;
                end
            end
            CFD_ST_MONITOR: begin
                if (sleep_deep) begin
                    nxt_state = CFD_ST_STARTUP;
                    nxt_tick_cnt = 16'h0000;
                end else if (fail_event) begin
                    nxt_state = CFD_ST_GATE_OFF;
                    nxt_cyc_cnt = GAP_CYC;
                end else if (mon_tick) begin
                    nxt_miss_cnt = edge_now ? 4'h0 : miss_cnt_ff + 4'h1;
                end
            end
            CFD_ST_GATE_OFF: begin
                // dead time with both gates closed
                nxt_cyc_cnt = cyc_cnt_ff - 8'h01;
                if (cyc_cnt_ff == 8'h01) begin
                    nxt_state = CFD_ST_RC_WAKE;
                    nxt_cyc_cnt = WAKE_CYC;
                end
            end
            CFD_ST_RC_WAKE: begin
                nxt_cyc_cnt = cyc_cnt_ff - 8'h01;
                if (cyc_cnt_ff == 8'h01) begin
                    nxt_state = CFD_ST_SAFE;
                end
            end
            CFD_ST_SAFE: begin
                nxt_state = CFD_ST_SAFE;
            end
            default: begin
                nxt_state = CFD_ST_IDLE;
            end
        endcase
    end

    // clock tree controls follow the next state
    always_comb begin
        nxt_clk_ctrl = '0;
        nxt_clk_ctrl.lfo_en = cfd_fuse_en && (nxt_state != CFD_ST_IDLE) && !sleep_deep;
        nxt_clk_ctrl.rc_osc_en = (nxt_state == CFD_ST_RC_WAKE) || (nxt_state == CFD_ST_SAFE);
        nxt_clk_ctrl.external_osc_clock_gate = (nxt_state == CFD_ST_IDLE) ||
                                 (nxt_state == CFD_ST_STARTUP) || (nxt_state == CFD_ST_MONITOR);
        nxt_clk_ctrl.rc_gate = nxt_state == CFD_ST_SAFE;
        nxt_clk_ctrl.clock_source_select = nxt_clk_ctrl.rc_osc_en ? `CFD_SRC_RC : `CFD_SRC_EXTERNAL_OSC_CLOCK;
    end

    // sequence registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_ff <= CFD_ST_IDLE;
            tick_cnt_ff <= 16'h0000;
            miss_cnt_ff <= 4'h0;
            cyc_cnt_ff <= 8'h00;
            clk_ctrl_ff <= '{1'b0, 1'b0, 1'b1, 1'b0, `CFD_SRC_EXTERNAL_OSC_CLOCK};
        end else begin
            state_ff <= nxt_state;
            tick_cnt_ff <= nxt_tick_cnt;
            miss_cnt_ff <= nxt_miss_cnt;
            cyc_cnt_ff <= nxt_cyc_cnt;
            clk_ctrl_ff <= nxt_clk_ctrl;
        end
    end

    // ---------------------------------------------------------------
    // failure register and interrupts
    // ---------------------------------------------------------------
    wire [1:0] irq_set = {ps_changed, fail_event};
    wire [1:0] irq_clr = (wr_acc && hit_stat) ? writedata[1:0] : 2'h0;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fail_flag_ff <= 1'(`CFD_FAILCSR_RST >> `CFD_FAIL_FLAG_BIT);
            fail_ie_ff <= 1'(`CFD_FAILCSR_RST >> `CFD_FAIL_IE_BIT);
            irq_stat_ff <= `CFD_IRQ_RST;
            irq_mask_ff <= `CFD_IRQ_RST;
            irq_ff <= 1'b0;
        end else begin
            fail_flag_ff <= fail_flag_ff || fail_event;
            fail_ie_ff <= fail_ie_ff || (wr_acc && hit_csr && writedata[`CFD_FAIL_IE_BIT]);
            // sticky events, set wins over clear
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
            if (wr_acc && hit_mask) begin
                irq_mask_ff <= writedata[1:0];
            end
            irq_ff <= (fail_flag_ff && fail_ie_ff) || |(irq_stat_ff & irq_mask_ff);
        end
    end

    // ---------------------------------------------------------------
    // bus slave: one wait cycle then answer
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            waitreq_ff <= 1'b1;
            rdata_ff <= 32'h00000000;
        end else begin
            waitreq_ff <= !(req && waitreq_ff);
            rdata_ff <= (read && waitreq_ff) ? rd_mux : 32'h00000000;
        end
    end

    cfd_prescaler u_prescaler (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_en(wr_acc && hit_ps),
        .wdata(writedata[7:0]),
        .force_safe(ps_force),
        .readback(ps_readback),
        .prescale_select(prescale_select),
        .changed(ps_changed)
    );

    assign readdata = rdata_ff;
    assign waitrequest = waitreq_ff;
    assign clk_ctrl = clk_ctrl_ff;
    assign irq = irq_ff;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_fail;
        fail_event;
    endsequence

    sequence s_switch;
        (!clk_ctrl_ff.external_osc_clock_gate && !clk_ctrl_ff.rc_gate) [*2] ##[1:300] clk_ctrl_ff.rc_gate;
    endsequence

    property p_switch;
        @(posedge sys_clk) disable iff (reset)
        s_fail |=> s_switch;
    endproperty
    a_switch: assert property (p_switch) else $error("safe switch sequence wrong");

    property p_no_overlap;
        @(posedge sys_clk) disable iff (reset)
        !(clk_ctrl_ff.external_osc_clock_gate && clk_ctrl_ff.rc_gate);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both clocks gated on");

    property p_safe_latched;
        @(posedge sys_clk) disable iff (reset)
        (state_ff == CFD_ST_SAFE) |=> (state_ff == CFD_ST_SAFE) && clk_ctrl_ff.rc_gate;
    endproperty
    a_safe_latched: assert property (p_safe_latched) else $error("left safe clock");

    property p_safe_div;
        @(posedge sys_clk) disable iff (reset)
        ps_force |=> ##1 (prescale_select == `CFD_PS_SAFE);
    endproperty
    a_safe_div: assert property (p_safe_div) else $error("safe divide not set");

    property p_fuse_off;
        @(posedge sys_clk) disable iff (reset)
        !cfd_fuse_en && (state_ff == CFD_ST_IDLE) |=> (state_ff == CFD_ST_IDLE) && !fail_flag_ff;
    endproperty
    a_fuse_off: assert property (p_fuse_off) else $error("active without fuse");

    property p_flag;
        @(posedge sys_clk) disable iff (reset)
        fail_event |=> fail_flag_ff [*8];
    endproperty
    a_flag: assert property (p_flag) else $error("failure flag not held");

    property p_irq;
        @(posedge sys_clk) disable iff (reset)
        (fail_flag_ff && fail_ie_ff) |=> irq_ff;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_ie_sticky;
        @(posedge sys_clk) disable iff (reset)
        fail_ie_ff |=> fail_ie_ff;
    endproperty
    a_ie_sticky: assert property (p_ie_sticky) else $error("enable cleared");

    property p_rc_off;
        @(posedge sys_clk) disable iff (reset)
        (state_ff == CFD_ST_MONITOR || state_ff == CFD_ST_STARTUP) |-> !clk_ctrl_ff.rc_osc_en;
    endproperty
    a_rc_off: assert property (p_rc_off) else $error("rc enabled while healthy");

    property p_sleep;
        @(posedge sys_clk) disable iff (reset)
        sleep_deep && (state_ff == CFD_ST_MONITOR) |=> (state_ff == CFD_ST_STARTUP) && !fail_flag_ff
            || $past(fail_flag_ff);
    endproperty
    a_sleep: assert property (p_sleep) else $error("detection not paused");

    property p_src;
        @(posedge sys_clk) disable iff (reset)
        clk_ctrl_ff.rc_gate |-> (clk_ctrl_ff.clock_source_select == `CFD_SRC_RC);
    endproperty
    a_src: assert property (p_src) else $error("wrong source code");

    property p_lfo;
        @(posedge sys_clk) disable iff (reset)
        (state_ff == CFD_ST_MONITOR) && !sleep_deep && !$past(sleep_deep) |-> clk_ctrl_ff.lfo_en;
    endproperty
    a_lfo: assert property (p_lfo) else $error("monitor oscillator off");

    property p_start;
        @(posedge sys_clk) disable iff (reset)
        (state_ff == CFD_ST_STARTUP) && !start_done |=> (state_ff == CFD_ST_STARTUP);
    endproperty
    a_start: assert property (p_start) else $error("failure during start-up");

endmodule // cfd_clock_fail_detector

// ### core/cfd_defines.svh
// constants of the clock failure detector: offsets, fields, resets, timing
`ifndef CFD_DEFINES_SVH
`define CFD_DEFINES_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define CFD_IDX_PRESCALE 8'h61
`define CFD_IDX_FAILCSR 8'h62
`define CFD_IDX_IRQ_STAT 8'h70
`define CFD_IDX_IRQ_MASK 8'h71
`define CFD_IDX_STATE 8'h72

// ---------------------------------------------------------------
// field positions and values
// ---------------------------------------------------------------
`define CFD_FAIL_IE_BIT 0
`define CFD_FAIL_FLAG_BIT 1
`define CFD_PCE_BIT 7
`define CFD_IRQ_FAIL_BIT 0
`define CFD_IRQ_PSCHG_BIT 1
`define CFD_PCE_ARM 8'h80
`define CFD_SRC_EXTERNAL_OSC_CLOCK 4'h0
`define CFD_SRC_RC 4'h2
`define CFD_PS_SAFE 4'h3
`define CFD_PS_RESET 4'h3
`define CFD_PS_MAX 4'h8
`define CFD_FAILCSR_RST 8'h00
`define CFD_IRQ_RST 2'h0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CFD_SYS_CLK_HZ 10000000
`define CFD_SYS_PERIOD_NS 100
`define CFD_MON_CLK_HZ 128000
`define CFD_EXTERNAL_OSC_CLOCK_MIN_HZ 256000
`define CFD_EXTERNAL_OSC_CLOCK_STARTUP_US 1000
`define CFD_FAIL_TICKS 2
`define CFD_PCE_WINDOW 3'h4
`define CFD_GATE_GAP_NS 200
`define CFD_RC_WAKE_NS 1000

`endif

// ### core/cfd_pkg.sv
// types shared by the clock failure detector
package cfd_pkg;

    // monitor and switch sequence
    typedef enum logic [2:0] {
        CFD_ST_IDLE = 3'b000,
        CFD_ST_STARTUP = 3'b001,
        CFD_ST_MONITOR = 3'b010,
        CFD_ST_GATE_OFF = 3'b011,
        CFD_ST_RC_WAKE = 3'b100,
        CFD_ST_SAFE = 3'b101
    } cfd_state_t;

    // clock tree controls driven to the oscillators and clock mux
    typedef struct packed {
        logic lfo_en;
        logic rc_osc_en;
        logic external_osc_clock_gate;
        logic rc_gate;
        logic [3:0] clock_source_select;
    } cfd_clk_ctrl_t;

endpackage

// ### core/cfd_prescaler.sv
// system clock prescale register with timed change procedure
`timescale 1ns/1ps
`include "cfd_defines.svh"

module cfd_prescaler
    import cfd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    input wire logic force_safe,
    output logic [7:0] readback,
    output logic [3:0] prescale_select,
    output logic changed
);

    logic pce_ff;
    logic [2:0] win_ff;
    logic [3:0] sel_ff;
    logic chg_ff;

    // ---------------------------------------------------------------
    // write decode
    // ---------------------------------------------------------------
    wire arm_wr = wr_en && (wdata == `CFD_PCE_ARM);
    wire sel_wr = wr_en && !wdata[`CFD_PCE_BIT] && pce_ff && (wdata[3:0] <= `CFD_PS_MAX);
    wire win_end = pce_ff && (win_ff == 3'h1);

    // change enable, window and divide selection
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pce_ff <= 1'b0;
            win_ff <= 3'h0;
            sel_ff <= `CFD_PS_RESET;
            chg_ff <= 1'b0;
        end else begin
            chg_ff <= 1'b0;
            if (force_safe) begin
                sel_ff <= `CFD_PS_SAFE;
                pce_ff <= 1'b0;
            end else if (sel_wr) begin
                sel_ff <= wdata[3:0];
                pce_ff <= 1'b0;
                chg_ff <= 1'b1;
            end else if (win_end) begin
                pce_ff <= 1'b0;
            end else if (arm_wr && !pce_ff) begin
                pce_ff <= 1'b1;
                win_ff <= `CFD_PCE_WINDOW;
            end
            if (pce_ff && !win_end) begin
                win_ff <= win_ff - 3'h1;
            end
        end
    end

    assign readback = {pce_ff, 3'h0, sel_ff};
    assign prescale_select = sel_ff;
    assign changed = chg_ff;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_arm;
        arm_wr && !pce_ff && !force_safe && !reset;
    endsequence

    property p_pce_window;
        @(posedge sys_clk) disable iff (reset)
        s_arm |=> pce_ff ##4 !pce_ff;
    endproperty
    a_pce_window: assert property (p_pce_window) else $error("change enable window wrong");

    property p_sel_needs_pce;
        @(posedge sys_clk) disable iff (reset)
        (!pce_ff && !force_safe) |=> (sel_ff == $past(sel_ff));
    endproperty
    a_sel_needs_pce: assert property (p_sel_needs_pce) else $error("select changed unarmed");

endmodule // cfd_prescaler

// ### tb/cfd_external_osc_clock_model.sv
// behavioural external oscillator for the detector bench
`timescale 1ns/1ps

module cfd_external_osc_clock_model (
    input wire logic sys_clk,
    input wire logic run,
    input wire logic [4:0] half,
    output logic external_osc_clock_out
);
    // --------
    // oscillator
    // --------
    logic [4:0] cnt = 5'h01;
    logic level_ff = 1'h0;
    // fast clock or none
    // level holds when stopped, as a dead crystal would
    always @(posedge sys_clk) begin
        if (run && cnt >= half) begin
            level_ff <= ~level_ff;
            cnt <= 5'h01;
        end else if (run) begin
            cnt <= cnt + 5'h01;
        end
    end
    assign external_osc_clock_out = level_ff;
endmodule // cfd_external_osc_clock_model

// ### tb/test_clock_failure_detector.sv
// self-checking bench of the clock failure detector
`timescale 1ns/1ps
`include "cfd_defines.svh"

module test_clock_failure_detector
    import cfd_pkg::*;
;
    // --------
    // stimulus and wiring
    // --------
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic read = 1'h0;
    logic write = 1'h0;
    logic fuse = 1'h0;
    logic tick = 1'h0;
    logic sleep = 1'h0;
    logic run = 1'h0;
    logic overlap = 1'h0;
    logic [4:0] half = 5'h02;
    logic [6:0] tcnt = 7'h00;
    logic [9:0] address = 10'h000;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic [31:0] q;
    logic [7:0] v;
    logic waitrequest;
    logic external_osc_clock;
    logic irq;
    logic [3:0] ps;
    cfd_clk_ctrl_t ctl;
    int fails = 0;
    int comparisons = 0;
    int seed = 52;
    int i;

    always #50 sys_clk = ~sys_clk;
    // monitor tick every 78 cycles, 128 kHz at 10 MHz
    always @(posedge sys_clk) begin
        tcnt <= (tcnt == 7'h4D) ? 7'h00 : tcnt + 7'h01;
        tick <= (tcnt == 7'h4D);
    end
    // both clock gates open at once would glitch
    always @(negedge sys_clk) if (ctl.external_osc_clock_gate === 1'h1 && ctl.rc_gate === 1'h1) overlap = 1'h1;

    cfd_external_osc_clock_model osc (.sys_clk(sys_clk), .run(run), .half(half), .external_osc_clock_out(external_osc_clock));

    cfd_clock_fail_detector #(.EXTERNAL_OSC_CLOCK_STARTUP_US(10)) DUT (.sys_clk(sys_clk), .reset(reset),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .cfd_fuse_en(fuse),
        .external_osc_clock_clk_in(external_osc_clock), .mon_tick(tick), .sleep_deep(sleep), .clk_ctrl(ctl),
        .prescale_select(ps), .irq(irq));

    task automatic results();
        if (fails == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // expected clock tree controls: monitor on, safe clock taken
    function automatic logic [31:0] exp_ctl(input logic on, input logic safe);
        exp_ctl = {24'h0, on, safe, !safe, safe, safe ? `CFD_SRC_RC : `CFD_SRC_EXTERNAL_OSC_CLOCK};
    endfunction

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        address <= {idx, 2'h0};
        writedata <= {24'h0, d};
        read <= ~wr;
        write <= wr;
        @(posedge sys_clk);
        while (waitrequest !== 1'h0 && n < 20) begin
            n++;
            @(posedge sys_clk);
        end
        if (n == 20) begin
            fails++;
            results();
        end
        q = readdata;
        read <= 1'h0;
        write <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'h0, idx, 8'h00);
        chk(q, exp);
    endtask

    task automatic wait_safe();
        int n;
        n = 0;
        while (ctl.rc_gate !== 1'h1 && n < 8000) begin
            n++;
            @(posedge sys_clk);
        end
        if (n == 8000) begin
            fails++;
            results();
        end
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic do_reset();
        reset <= 1'h1;
        repeat (3) @(posedge sys_clk);
        reset <= 1'h0;
    endtask

    // --------
    // main sequence
    // --------
    initial begin
        do_reset();
        rd(`CFD_IDX_FAILCSR, 32'h0);
        rd(`CFD_IDX_PRESCALE, 32'h3);
        rd(8'($random(seed)) & 8'h3F, 32'h0);
        repeat (600) @(posedge sys_clk);
        chk(32'(ctl), exp_ctl(1'h0, 1'h0));
        fuse <= 1'h1;
        run <= 1'h1;
        half <= 5'(($random(seed) & 7) + 1);
        repeat (900) @(posedge sys_clk);
        chk(32'(ctl), exp_ctl(1'h1, 1'h0));
        for (i = 0; i < 3; i++) begin
            v = 8'($unsigned($random(seed)) % 9);
            bus(1'h1, `CFD_IDX_PRESCALE, 8'h80);
            bus(1'h1, `CFD_IDX_PRESCALE, v);
            @(posedge sys_clk);
            chk(32'(ps), 32'(v));
        end
        bus(1'h1, `CFD_IDX_PRESCALE, 8'h09);
        bus(1'h1, `CFD_IDX_PRESCALE, 8'h80);
        bus(1'h1, `CFD_IDX_PRESCALE, 8'h0C);
        @(posedge sys_clk);
        chk(32'(ps), 32'(v));
        sleep <= 1'h1;
        run <= 1'h0;
        repeat (900) @(posedge sys_clk);
        chk({ctl.external_osc_clock_gate, ctl.rc_gate}, 32'h2);
        sleep <= 1'h0;
        wait_safe();
        chk(32'(ctl), exp_ctl(1'h1, 1'h1));
        chk(32'(ps), 32'(`CFD_PS_SAFE));
        rd(`CFD_IDX_FAILCSR, 32'h2);
        rd(`CFD_IDX_IRQ_STAT, 32'h3);
        rd(`CFD_IDX_STATE, 32'({1'h1, CFD_ST_SAFE}));
        chk(32'(irq), 32'h0);
        bus(1'h1, `CFD_IDX_IRQ_MASK, 8'h01);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h1);
        bus(1'h1, `CFD_IDX_IRQ_STAT, 8'h01);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h0);
        bus(1'h1, `CFD_IDX_FAILCSR, 8'h01);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h1);
        bus(1'h1, `CFD_IDX_FAILCSR, 8'h00);
        rd(`CFD_IDX_FAILCSR, 32'h3);
        bus(1'h1, `CFD_IDX_PRESCALE, 8'h80);
        bus(1'h1, `CFD_IDX_PRESCALE, 8'h00);
        @(posedge sys_clk);
        chk(32'(ps), 32'h0);
        run <= 1'h1;
        repeat (900) @(posedge sys_clk);
        chk(32'(ctl.rc_gate), 32'h1);
        do_reset();
        repeat (900) @(posedge sys_clk);
        chk(32'(ctl), exp_ctl(1'h1, 1'h0));
        rd(`CFD_IDX_FAILCSR, 32'h0);
        run <= 1'h0;
        wait_safe();
        chk(32'(ctl), exp_ctl(1'h1, 1'h1));
        chk(32'(overlap), 32'h0);
        results();
    end
endmodule // test_clock_failure_detector
